// >>> saw_safety_fault_monitor.sv
`timescale 1ns/1ps
// How it works
// - Retract not done within 7 s: motor off, retract, hold, code two
// - Lowered and raised switches both on: fault, code three
// - Guard pressure switch opens while cutting: fault, code four
// - Fitted clamp pressure switch opens while cutting: fault, code five
// - Clamp pressure faults: motor off, saw retracts, others hold
// - Lowered switch opens with raise coil off: fault, code six
// - Latched fault code flashes repeatedly on the fault lamp
// - Any latched fault inhibits starting the saw drive
// - Off button or power cycle clears a latched monitoring fault
// - Air supply fault lights the pressure lamp-button steadily
// - Low pressure stops motor, retracts saw, holds other cylinders
// - Pressure fault held until pressure back and button pressed
// - Button lamp flashes during run-up, two-hand off; steady after
module saw_safety_fault_monitor
  import ssfm_pkg::*;
#(
  parameter int unsigned RETRACT_CYC = RETRACT_CYCLES,
  parameter int unsigned ON_CYC      = FLASH_ON_CYC,
  parameter int unsigned OFF_CYC     = FLASH_OFF_CYC,
  parameter int unsigned PAUSE_CYC   = FLASH_PAUSE_CYC,
  parameter int unsigned BLINK_CYC   = RUNUP_BLINK_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Machine sensing
  input  wire ssfm_sense_s sense,
  input  wire logic        saw_raise_coil,
  input  wire logic        cutting,
  input  wire logic        retracting,
  // Operator controls
  input  wire logic        start_request,
  input  wire logic        off_button,
  input  wire logic        pressure_ack_button,
  input  wire logic        motor_run_up_done,
  // Actuation
  output ssfm_act_s        act,
  output logic             drive_start_allow,
  output logic             two_hand_enable,
  // Lamps
  output logic             fault_signal_lamp,
  output logic             pressure_ack_lamp_button,
  output logic             double_button_lamp,
  // Status
  output logic [CODE_W-1:0] fault_code,
  output logic             pressure_fault
);

  //////////////////////////////////////////////////////////////////////////////

  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic              pfault_reg;
  logic              pfault_next;
  logic              lowered_q_reg;
  logic              lowered_q_next;
  logic              retract_late;
  logic [CODE_W-1:0] detect;
  logic              stop_all;
  logic [TMR_W-1:0]  blink_reg;
  logic [TMR_W-1:0]  blink_next;
  logic              blink_ph_reg;
  logic              blink_ph_next;

  localparam logic [TMR_W-1:0] RETRACT_T = TMR_W'(RETRACT_CYC);
  localparam logic [TMR_W-1:0] BLINK_T   = TMR_W'(BLINK_CYC - 1);

  // Retract watchdog
  ssfm_timer u_retract_tmr (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .run     (retracting && sense.saw_lowered_switch == 1'b0),
    .limit   (RETRACT_T),
    .expired (retract_late)
  );

  // Priority only decides same-cycle ties; first detected is latched
  function automatic logic [CODE_W-1:0] classify(
    input ssfm_sense_s s,
    input logic        late,
    input logic        cut,
    input logic        coil,
    input logic        low_q
  );
    logic [CODE_W-1:0] c;
    c = CODE_NONE;
    if (low_q && !s.saw_lowered_switch && !coil) begin
      c = CODE_LOWERED;
    end
    if (cut && s.clamp_fitted && !s.clamp_pressure_switch) begin
      c = CODE_CLAMP;
    end
    if (cut && !s.guard_pressure_switch) begin
      c = CODE_GUARD;
    end
    if (s.saw_lowered_switch && s.saw_raised_switch) begin
      c = CODE_BOTH_SW;
    end
    if (late) begin
      c = CODE_RETRACT;
    end
    return c;
  endfunction

  assign detect = classify(sense, retract_late, cutting, saw_raise_coil,
                           lowered_q_reg);

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    code_next      = code_reg;
    pfault_next    = pfault_reg;
    lowered_q_next = sense.saw_lowered_switch;
    if (code_reg == CODE_NONE) begin
      code_next = detect;
    end else if (off_button) begin
      code_next = detect;
    end
    if (!sense.pressure_ok) begin
      pfault_next = 1'b1;
    end else if (pfault_reg && pressure_ack_button) begin
      pfault_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      code_reg      <= CODE_NONE;
      pfault_reg    <= 1'b0;
      lowered_q_reg <= 1'b0;
    end else begin
      code_reg      <= code_next;
      pfault_reg    <= pfault_next;
      lowered_q_reg <= lowered_q_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Run-up blink for the double push button
  always_comb begin
    blink_next    = blink_reg + 1'b1;
    blink_ph_next = blink_ph_reg;
    if (motor_run_up_done) begin
      blink_next    = '0;
      blink_ph_next = 1'b1;
    end else if (blink_reg >= BLINK_T) begin
      blink_next    = '0;
      blink_ph_next = !blink_ph_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      blink_reg    <= '0;
      blink_ph_reg <= 1'b0;
    end else begin
      blink_reg    <= blink_next;
      blink_ph_reg <= blink_ph_next;
    end
  end

  assign double_button_lamp = blink_ph_reg;
  assign two_hand_enable    = motor_run_up_done && !stop_all;

  //////////////////////////////////////////////////////////////////////////////

  ssfm_flasher #(
    .ON_CYC    (ON_CYC),
    .OFF_CYC   (OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flash (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .code    (code_reg),
    .lamp    (fault_signal_lamp)
  );

  assign stop_all = (code_reg != CODE_NONE) || pfault_reg;

  // Motor off, saw retracts, other cylinders hold on any fault
  assign act.motor_enable      = !stop_all;
  assign act.saw_valve_retract = stop_all;
  assign act.guard_valve_hold  = stop_all;
  assign act.clamp_valve_hold  = stop_all;
  assign drive_start_allow     = start_request && !stop_all;

  assign pressure_ack_lamp_button = pfault_reg;
  assign fault_code               = code_reg;
  assign pressure_fault           = pfault_reg;

  //////////////////////////////////////////////////////////////////////////////

  // Fault conditions seen from the inputs, for the checks below
  logic             guard_cond;
  logic             clamp_cond;
  logic             both_cond;
  logic [TMR_W-1:0] lit_run_reg;
  logic [TMR_W-1:0] lit_run_next;

  localparam logic [TMR_W-1:0] ON_LEN = TMR_W'(ON_CYC);

  assign guard_cond = cutting && !sense.guard_pressure_switch;
  assign clamp_cond = cutting && sense.clamp_fitted &&
                      !sense.clamp_pressure_switch;
  assign both_cond  = sense.saw_lowered_switch && sense.saw_raised_switch;

  // Length of the current fault lamp pulse
  always_comb begin
    lit_run_next = '0;
    if (fault_signal_lamp) begin
      lit_run_next = lit_run_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lit_run_reg <= '0;
    end else begin
      lit_run_reg <= lit_run_next;
    end
  end

  both_sw_latch_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE && sense.saw_lowered_switch &&
     sense.saw_raised_switch && !retract_late)
    |=> code_reg == CODE_BOTH_SW)
    else $error("both switches fault not latched");

  retract_late_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE && retract_late) |=> code_reg == CODE_RETRACT)
    else $error("retract timeout not latched");

  guard_open_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE && guard_cond && !both_cond && !retract_late)
    |=> code_reg == CODE_GUARD)
    else $error("guard fault not latched");

  clamp_open_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE && clamp_cond && !guard_cond && !both_cond &&
     !retract_late) |=> code_reg == CODE_CLAMP)
    else $error("clamp fault not latched");

  lowered_wrong_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE && $past(rstn) &&
     $fell(sense.saw_lowered_switch) && !saw_raise_coil && !retract_late &&
     !both_cond && !guard_cond && !clamp_cond)
    |=> code_reg == CODE_LOWERED)
    else $error("lowered switch fault not latched");

  first_kept_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg != CODE_NONE && !off_button) |=> $stable(code_reg))
    else $error("latched fault code changed");

  fault_stops_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg != CODE_NONE) |-> (!act.motor_enable &&
     act.saw_valve_retract && !drive_start_allow))
    else $error("fault did not stop drive");

  clamp_holds_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_CLAMP || code_reg == CODE_GUARD) |->
    (!act.motor_enable && act.saw_valve_retract &&
     act.guard_valve_hold && act.clamp_valve_hold))
    else $error("clamp fault did not hold cylinders");

  off_clears_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (off_button && detect == CODE_NONE) |=> code_reg == CODE_NONE)
    else $error("off button did not clear fault");

  sequence s_pfault_held;
    pfault_reg && sense.pressure_ok && !pressure_ack_button;
  endsequence

  press_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_pfault_held |=> pressure_ack_lamp_button)
    else $error("pressure fault dropped without acknowledge");

  press_lamp_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !sense.pressure_ok |=> pressure_ack_lamp_button[*2])
    else $error("pressure lamp not steady on");

  press_stops_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pfault_reg |-> (!act.motor_enable && act.saw_valve_retract &&
     act.guard_valve_hold && !drive_start_allow && !two_hand_enable))
    else $error("pressure fault did not stop drive");

  lamp_runs_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (code_reg == CODE_NONE)[*3] |-> !fault_signal_lamp)
    else $error("fault lamp lit without fault");

  lamp_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($fell(fault_signal_lamp) && code_reg != CODE_NONE) |->
    lit_run_reg == ON_LEN)
    else $error("fault lamp pulse length wrong");

  runup_block_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !motor_run_up_done |-> !two_hand_enable)
    else $error("two-hand enabled during run-up");

  runup_steady_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    motor_run_up_done[*2] |-> double_button_lamp)
    else $error("button lamp not steady after run-up");

endmodule

// >>> ssfm_flasher.sv
`timescale 1ns/1ps
module ssfm_flasher
  import ssfm_pkg::*;
#(
  parameter int unsigned ON_CYC    = FLASH_ON_CYC,
  parameter int unsigned OFF_CYC   = FLASH_OFF_CYC,
  parameter int unsigned PAUSE_CYC = FLASH_PAUSE_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Code to show, zero for none
  input  wire logic [CODE_W-1:0] code,
  // Lamp drive
  output logic                   lamp
);

  ssfm_flash_e       st_reg;
  ssfm_flash_e       st_next;
  logic [TMR_W-1:0]  tmr_reg;
  logic [TMR_W-1:0]  tmr_next;
  logic [CODE_W-1:0] cnt_reg;
  logic [CODE_W-1:0] cnt_next;
  logic              lamp_reg;
  logic              lamp_next;

  localparam logic [TMR_W-1:0] ON_T    = TMR_W'(ON_CYC - 1);
  localparam logic [TMR_W-1:0] OFF_T   = TMR_W'(OFF_CYC - 1);
  localparam logic [TMR_W-1:0] PAUSE_T = TMR_W'(PAUSE_CYC - 1);

  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg + 1'b1;
    cnt_next  = cnt_reg;
    unique case (st_reg)
      FL_IDLE: begin
        tmr_next = '0;
        cnt_next = '0;
        if (code != CODE_NONE) begin
          st_next = FL_ON;
        end
      end
      FL_ON: begin
        if (tmr_reg >= ON_T) begin
          tmr_next = '0;
          cnt_next = cnt_reg + 1'b1;
          st_next  = (cnt_reg + 1'b1 >= code) ? FL_PAUSE : FL_OFF;
        end
      end
      FL_OFF: begin
        if (tmr_reg >= OFF_T) begin
          tmr_next = '0;
          st_next  = FL_ON;
        end
      end
      FL_PAUSE: begin
        if (tmr_reg >= PAUSE_T) begin
          tmr_next = '0;
          cnt_next = '0;
          st_next  = (code != CODE_NONE) ? FL_ON : FL_IDLE;
        end
      end
    endcase
    if (code == CODE_NONE) begin
      st_next = FL_IDLE;
    end
    lamp_next = (st_next == FL_ON);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg   <= FL_IDLE;
      tmr_reg  <= '0;
      cnt_reg  <= '0;
      lamp_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      cnt_reg  <= cnt_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp = lamp_reg;

endmodule

// >>> ssfm_machine.sv
`timescale 1ns/1ps
module ssfm_machine
  import ssfm_pkg::*;
(
  // Switch states from the machine
  input  wire logic   lowered,
  input  wire logic   raised,
  input  wire logic   guard_ok,
  input  wire logic   clamp_ok,
  input  wire logic   fitted,
  input  wire logic   air_ok,
  // Packed view for the monitor
  output ssfm_sense_s sense
);
  // Air sense level passed straight through, not latched
  assign sense = '{lowered, raised, guard_ok, clamp_ok, fitted, air_ok};
endmodule

// >>> ssfm_pkg.sv
package ssfm_pkg;

  // Timing at 20 MHz
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RETRACT_LIMIT_S = 7;
  localparam int unsigned RETRACT_CYCLES  = RETRACT_LIMIT_S * CLK_HZ;
  localparam int unsigned FLASH_ON_MS     = 300;
  localparam int unsigned FLASH_OFF_MS    = 300;
  localparam int unsigned FLASH_PAUSE_MS  = 1500;
  localparam int unsigned RUNUP_BLINK_MS  = 250;
  localparam int unsigned FLASH_ON_CYC    = FLASH_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_OFF_CYC   = FLASH_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_PAUSE_CYC = FLASH_PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned RUNUP_BLINK_CYC = RUNUP_BLINK_MS * (CLK_HZ / 1000);

  localparam int TMR_W  = 28;
  localparam int CODE_W = 3;

  // Fault codes as flashed on the fault lamp
  localparam logic [2:0] CODE_NONE    = 3'h0;
  localparam logic [2:0] CODE_RETRACT = 3'h2;
  localparam logic [2:0] CODE_BOTH_SW = 3'h3;
  localparam logic [2:0] CODE_GUARD   = 3'h4;
  localparam logic [2:0] CODE_CLAMP   = 3'h5;
  localparam logic [2:0] CODE_LOWERED = 3'h6;

  typedef struct packed {
    logic saw_lowered_switch;
    logic saw_raised_switch;
    logic guard_pressure_switch;
    logic clamp_pressure_switch;
    logic clamp_fitted;
    logic pressure_ok;
  } ssfm_sense_s;

  typedef struct packed {
    logic motor_enable;
    logic saw_valve_retract;
    logic guard_valve_hold;
    logic clamp_valve_hold;
  } ssfm_act_s;

  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} ssfm_flash_e;

endpackage

// >>> ssfm_timer.sv
`timescale 1ns/1ps
module ssfm_timer
  import ssfm_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Control
  input  wire logic             run,
  input  wire logic [TMR_W-1:0] limit,
  // Status
  output logic                  expired
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg < limit) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = run && (cnt_reg >= limit);

endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ssfm_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              lowered = 1'b1;
  logic              raised = 1'b0;
  logic              guard_ok = 1'b1;
  logic              clamp_ok = 1'b1;
  logic              fitted = 1'b1;
  logic              air_ok = 1'b1;
  logic              coil = 1'b0;
  logic              cutting = 1'b0;
  logic              retracting = 1'b0;
  logic              start_req = 1'b1;
  logic              off_btn = 1'b0;
  logic              ack_btn = 1'b0;
  logic              runup = 1'b0;
  ssfm_sense_s       sense;
  ssfm_act_s         act;
  logic              dsa;
  logic              the;
  logic              fl;
  logic              plb;
  logic              dbl;
  logic [CODE_W-1:0] code;
  logic              pf;
  int                err_total = 0;
  int                checked = 0;

  always #25 ref_clk = ~ref_clk;

  ssfm_machine u_ssfm_machine (.lowered(lowered), .raised(raised),
    .guard_ok(guard_ok), .clamp_ok(clamp_ok), .fitted(fitted),
    .air_ok(air_ok), .sense(sense));

  saw_safety_fault_monitor #(.RETRACT_CYC(20), .ON_CYC(3), .OFF_CYC(3),
    .PAUSE_CYC(8), .BLINK_CYC(4)) u_saw_safety_fault_monitor (
    .ref_clk(ref_clk), .rstn(rstn), .sense(sense), .saw_raise_coil(coil),
    .cutting(cutting), .retracting(retracting), .start_request(start_req),
    .off_button(off_btn), .pressure_ack_button(ack_btn),
    .motor_run_up_done(runup), .act(act), .drive_start_allow(dsa),
    .two_hand_enable(the), .fault_signal_lamp(fl),
    .pressure_ack_lamp_button(plb), .double_button_lamp(dbl),
    .fault_code(code), .pressure_fault(pf));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic see(input logic [2:0] c, input logic ok);
    chk("code", {5'h0, code}, {5'h0, c});
    chk("start", {7'h0, dsa}, {7'h0, ok});
  endtask

  task automatic act_chk(input logic mot);
    chk("act", {4'h0, act}, {4'h0, mot, ~mot, ~mot, ~mot});
  endtask

  // Operator clears with the off half of the double button
  task automatic clr();
    off_btn = 1'b1;
    cyc(1);
    off_btn = 1'b0;
    cyc(2);
  endtask

  // First pulse one cycle after latch; pause keeps the next group out
  task automatic flashes(input int n);
    int   k;
    logic p;
    k = 0;
    p = fl;
    repeat (n * 6 + 4) begin
      cyc(1);
      if (fl === 1'b1 && p !== 1'b1) k++;
      p = fl;
    end
    chk("flashes", k[7:0], n[7:0]);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_guard();
    cutting = 1'b1;
    guard_ok = 1'b0;
    flashes(4);
    see(CODE_GUARD, 1'b0);
    act_chk(1'b0);
    cutting = 1'b0;
    guard_ok = 1'b1;
    clr();
    see(CODE_NONE, 1'b1);
    $display("guard test done");
  endtask

  task automatic t_clamp();
    cutting = 1'b1;
    fitted = 1'b0;
    clamp_ok = 1'b0;
    cyc(4);
    see(CODE_NONE, 1'b1);
    fitted = 1'b1;
    flashes(5);
    see(CODE_CLAMP, 1'b0);
    act_chk(1'b0);
    cutting = 1'b0;
    clamp_ok = 1'b1;
    clr();
    $display("clamp test done");
  endtask

  task automatic t_both();
    raised = 1'b1;
    flashes(3);
    see(CODE_BOTH_SW, 1'b0);
    cutting = 1'b1;
    guard_ok = 1'b0;
    cyc(4);
    see(CODE_BOTH_SW, 1'b0);
    cutting = 1'b0;
    guard_ok = 1'b1;
    raised = 1'b0;
    clr();
    see(CODE_NONE, 1'b1);
    $display("both switches test done");
  endtask

  task automatic t_lowered();
    lowered = 1'b0;
    flashes(6);
    see(CODE_LOWERED, 1'b0);
    lowered = 1'b1;
    clr();
    coil = 1'b1;
    cyc(1);
    lowered = 1'b0;
    cyc(4);
    see(CODE_NONE, 1'b1);
    $display("lowered switch test done");
  endtask

  task automatic t_retract();
    coil = 1'b0;
    retracting = 1'b1;
    cyc(15);
    see(CODE_NONE, 1'b1);
    cyc(10);
    see(CODE_RETRACT, 1'b0);
    act_chk(1'b0);
    retracting = 1'b0;
    lowered = 1'b1;
    clr();
    $display("retract test done");
  endtask

  task automatic t_press();
    air_ok = 1'b0;
    ack_btn = 1'b1;
    repeat (12) begin
      cyc(1);
      chk("plamp", {7'h0, plb}, 8'h01);
    end
    ack_btn = 1'b0;
    act_chk(1'b0);
    see(CODE_NONE, 1'b0);
    air_ok = 1'b1;
    cyc(3);
    chk("pfault", {7'h0, pf}, 8'h01);
    ack_btn = 1'b1;
    cyc(1);
    ack_btn = 1'b0;
    cyc(2);
    chk("plamp", {7'h0, plb}, 8'h00);
    see(CODE_NONE, 1'b1);
    $display("pressure test done");
  endtask

  task automatic t_runup();
    int k;
    k = 0;
    repeat (20) begin
      cyc(1);
      if (dbl === 1'b1) k++;
      chk("twohand", {7'h0, the}, 8'h00);
    end
    chk("blink", {7'h0, k > 0 && k < 20}, 8'h01);
    runup = 1'b1;
    cyc(3);
    repeat (10) begin
      cyc(1);
      chk("dlamp", {6'h0, dbl, the}, 8'h03);
    end
    start_req = 1'b0;
    cyc(1);
    chk("start", {7'h0, dsa}, 8'h00);
    start_req = 1'b1;
    $display("run-up test done");
  endtask

  task automatic t_power();
    cutting = 1'b1;
    guard_ok = 1'b0;
    cyc(3);
    rstn = 1'b0;
    cutting = 1'b0;
    guard_ok = 1'b1;
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    see(CODE_NONE, 1'b1);
    act_chk(1'b1);
    $display("power cycle test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    cyc(10);
    rstn = 1'b1;
    cyc(1);
    see(CODE_NONE, 1'b1);
    t_runup();
    t_guard();
    t_clamp();
    t_both();
    t_lowered();
    t_retract();
    t_press();
    t_power();
    complete_run();
  end
endmodule
